// ==== ctal_consts.svh ====
// constants for the transfer, arithmetic, logic and shift core
// assumes: included by bare name from each design file that needs it
`ifndef CTAL_CONSTS_SVH
`define CTAL_CONSTS_SVH

// ----------------------------------------------------------------
// flag register bit positions and reset values
// ----------------------------------------------------------------
`define CTAL_FLAG_C 0
`define CTAL_FLAG_V 1
`define CTAL_FLAG_Z 2
`define CTAL_FLAG_N 3
`define CTAL_FLAG_H 5
`define CTAL_FLAGS_RESET 8'h00
`define CTAL_REG_RESET 16'h0000

// ----------------------------------------------------------------
// addressing and datapath figures
// ----------------------------------------------------------------
`define CTAL_SP_IDX 3'h7
`define CTAL_BYTE_STEP 16'h0001
`define CTAL_WORD_STEP 16'h0002
`define CTAL_ABS8_PAGE 8'hff
`define CTAL_WORD_ALIGN 16'hfffe
`define CTAL_LANE_HIGH 2'b10
`define CTAL_LANE_LOW 2'b01
`define CTAL_LANE_BOTH 2'b11
`define CTAL_BCD_DIGIT_MAX 4'h9
`define CTAL_BCD_BYTE_MAX 8'h99
`define CTAL_BCD_FIX 4'h6
`define CTAL_PTR_STEP_ONE 2'h1
`define CTAL_PTR_STEP_TWO 2'h2

`endif

// ==== ctal_core.sv ====
// execution core: transfers, arithmetic, logic and shifts on the general registers
// assumes: memory answers each request with a one-cycle MEM_ACK; commands are
// offered only while CMD_BUSY is low
`timescale 1ns/1ps
`default_nettype none
`include "ctal_consts.svh"

module ctal_core (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RESETN,
  // command
  input wire logic CMD_START,
  input wire ctal_pkg::ctal_op_t CMD_OP,
  input wire logic CMD_WORD,
  input wire ctal_pkg::ctal_mode_t CMD_MODE,
  input wire logic CMD_STORE,
  input wire logic [3:0] CMD_DST,
  input wire logic [3:0] CMD_SRC,
  input wire logic [2:0] CMD_PTR,
  input wire logic [15:0] CMD_IMM,
  // status
  output logic CMD_BUSY,
  output logic CMD_DONE,
  output logic CMD_ILLEGAL,
  output logic [7:0] FLAGS,
  // memory
  output logic MEM_REQ,
  output logic MEM_WE,
  output logic MEM_WORD,
  output logic [15:0] MEM_ADDR,
  output logic [15:0] MEM_WDATA,
  input wire logic [15:0] MEM_RDATA,
  input wire logic MEM_ACK,
  // register view
  input wire logic [2:0] DBG_SEL,
  output logic [15:0] DBG_DATA
);
  import ctal_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] word_of(input logic [127:0] f, input logic [2:0] i);
    return f[{i, 4'h0} +: 16];
  endfunction

  // byte index: bits 2..0 pick the register, bit 3 set picks the low half
  function automatic logic [7:0] byte_of(input logic [127:0] f, input logic [3:0] i);
    logic [15:0] w;
    w = f[{i[2:0], 4'h0} +: 16];
    return i[3] ? w[7:0] : w[15:8];
  endfunction

  function automatic logic [7:0] with_nz(input logic [7:0] f, input logic [15:0] r, input logic word);
    logic [7:0] o;
    o = f;
    o[`CTAL_FLAG_N] = word ? r[15] : r[7];
    o[`CTAL_FLAG_Z] = word ? (r == 16'h0000) : (r[7:0] == 8'h00);
    return o;
  endfunction

  // returns {half carry, overflow, carry, result}
  function automatic logic [18:0] arith(input logic [15:0] x, input logic [15:0] y,
                                        input logic cin, input logic sub, input logic word);
    logic [16:0] r;
    logic [4:0] hb;
    logic [12:0] hw;
    logic sx, sy, sr, v;
    r = sub ? ({1'b0, x} - {1'b0, y} - {16'h0000, cin}) : ({1'b0, x} + {1'b0, y} + {16'h0000, cin});
    hb = sub ? ({1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, cin}) : ({1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin});
    hw = sub ? ({1'b0, x[11:0]} - {1'b0, y[11:0]}) : ({1'b0, x[11:0]} + {1'b0, y[11:0]});
    sx = word ? x[15] : x[7];
    sy = word ? y[15] : y[7];
    sr = word ? r[15] : r[7];
    v = sub ? ((sx ^ sy) & (sx ^ sr)) : (~(sx ^ sy) & (sx ^ sr));
    return {word ? hw[12] : hb[4], v, word ? r[16] : r[8], r[15:0]};
  endfunction

  // ----------------------------------------------------------------
  // reset release and command capture
  // ----------------------------------------------------------------
  logic [1:0] rst_sync;
  wire rst_n = rst_sync[1];

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) rst_sync <= 2'b00;
    else rst_sync <= {rst_sync[0], 1'b1};
  end

  ctal_state_t state_q;
  ctal_op_t op_q;
  ctal_mode_t mode_q;
  logic word_q, store_q;
  logic [3:0] dst_q, src_q;
  logic [2:0] ptr_q;
  logic [15:0] imm_q;
  logic [7:0] flag_q;
  logic [127:0] file;

  // stack forms are recast as fixed word transfers through the stack pointer
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      op_q <= transfer_op;
      mode_q <= mode_register;
      word_q <= 1'b0;
      store_q <= 1'b0;
      dst_q <= 4'h0;
      src_q <= 4'h0;
      ptr_q <= 3'h0;
      imm_q <= 16'h0000;
    end else if (state_q == st_idle && CMD_START) begin
      op_q <= CMD_OP;
      dst_q <= CMD_DST;
      src_q <= CMD_SRC;
      imm_q <= CMD_IMM;
      word_q <= (CMD_OP == stack_load_op || CMD_OP == stack_store_op) ? 1'b1 : CMD_WORD;
      mode_q <= (CMD_OP == stack_load_op) ? mode_postinc : (CMD_OP == stack_store_op) ? mode_predec : CMD_MODE;
      store_q <= (CMD_OP == stack_store_op) ? 1'b1 : (CMD_OP == stack_load_op) ? 1'b0 : CMD_STORE;
      ptr_q <= (CMD_OP == stack_load_op || CMD_OP == stack_store_op) ? `CTAL_SP_IDX : CMD_PTR;
    end
  end

  // ----------------------------------------------------------------
  // legality of the captured command
  // ----------------------------------------------------------------
  wire is_reg = mode_q == mode_register;
  wire is_imm = mode_q == mode_immediate;
  wire mem_access = (op_q == transfer_op || op_q == stack_load_op || op_q == stack_store_op) && !is_reg && !is_imm;
  wire xfer_ok = !(mode_q == mode_abs8 && word_q) && !(store_q && (is_reg || is_imm))
                 && !(mode_q == mode_predec && !store_q) && !(mode_q == mode_postinc && store_q)
                 && !(!word_q && ptr_q == `CTAL_SP_IDX && (mode_q == mode_predec || mode_q == mode_postinc));
  wire pstep_ok = is_reg && (imm_q[1:0] == `CTAL_PTR_STEP_ONE || imm_q[1:0] == `CTAL_PTR_STEP_TWO);
  logic cmd_ok;

  always_comb begin
    case (op_q)
      // word modes, short absolute byte only
      // byte stepping of stack pointer refused
      transfer_op: cmd_ok = xfer_ok;
      stack_load_op, stack_store_op: cmd_ok = 1'b1;
      sum_op: cmd_ok = is_reg || (is_imm && !word_q);
      difference_op: cmd_ok = is_reg;
      compare_op: cmd_ok = is_reg || (is_imm && !word_q);
      sum_with_carry_op, difference_with_borrow_op, and_op, or_op, xor_op: cmd_ok = (is_reg || is_imm) && !word_q;
      pointer_step_up_op, pointer_step_down_op: cmd_ok = pstep_ok;
      unsigned_product_op, unsigned_quotient_op: cmd_ok = is_reg;
      default: cmd_ok = is_reg && !word_q;
    endcase
  end

  // ----------------------------------------------------------------
  // operands and arithmetic
  // ----------------------------------------------------------------
  wire [15:0] dw = word_of(file, dst_q[2:0]);
  wire [15:0] sw = word_of(file, src_q[2:0]);
  wire [7:0] db = byte_of(file, dst_q);
  wire [7:0] sb = is_imm ? imm_q[7:0] : byte_of(file, src_q);
  wire [15:0] pv = word_of(file, ptr_q);
  wire [15:0] step = word_q ? `CTAL_WORD_STEP : `CTAL_BYTE_STEP;
  wire c_in = flag_q[`CTAL_FLAG_C];
  wire is_sub = op_q == difference_op || op_q == difference_with_borrow_op || op_q == step_down_op
                || op_q == compare_op || op_q == twos_complement_op;
  wire use_c = op_q == sum_with_carry_op || op_q == difference_with_borrow_op;
  wire is_step = op_q == step_up_op || op_q == step_down_op;
  wire [15:0] ar_x = (op_q == twos_complement_op) ? 16'h0000 : (word_q ? dw : {8'h00, db});
  wire [15:0] ar_y = is_step ? `CTAL_BYTE_STEP : (op_q == twos_complement_op) ? {8'h00, db}
                     : (word_q ? sw : {8'h00, sb});
  wire [18:0] ar = arith(ar_x, ar_y, use_c & c_in, is_sub, word_q);
  wire [15:0] pstep = {14'h0000, imm_q[1:0]};
  wire fix_lo = flag_q[`CTAL_FLAG_H] || (db[3:0] > `CTAL_BCD_DIGIT_MAX);
  wire fix_hi = c_in || (db > `CTAL_BCD_BYTE_MAX);
  wire [7:0] daa_adj = {fix_hi ? `CTAL_BCD_FIX : 4'h0, fix_lo ? `CTAL_BCD_FIX : 4'h0};
  wire [7:0] das_adj = {c_in ? `CTAL_BCD_FIX : 4'h0, flag_q[`CTAL_FLAG_H] ? `CTAL_BCD_FIX : 4'h0};
  wire [15:0] prod = {8'h00, dw[7:0]} * {8'h00, sb};
  wire div_zero = sb == 8'h00;
  wire [15:0] quo = div_zero ? 16'h0000 : dw / {8'h00, sb};
  wire [15:0] rem = div_zero ? 16'h0000 : dw % {8'h00, sb};
  wire [7:0] sh_res;
  wire sh_c, sh_v;

  ctal_shift u_shift (
    .op(op_q),
    .val(db),
    .c_in(c_in),
    .res(sh_res),
    .c_out(sh_c),
    .v_out(sh_v)
  );

  // ----------------------------------------------------------------
  // result selection; byte results sit in both halves
  // ----------------------------------------------------------------
  logic [15:0] alu_res;
  logic [7:0] alu_flags;
  logic alu_wr, alu_word;

  always_comb begin
    alu_res = {db, db};
    alu_flags = flag_q;
    alu_wr = 1'b1;
    alu_word = 1'b0;
    case (op_q)
      transfer_op: begin
        alu_word = word_q;
        alu_res = word_q ? (is_imm ? imm_q : sw) : {sb, sb};
        alu_flags = with_nz(flag_q, alu_res, word_q);
        alu_flags[`CTAL_FLAG_V] = 1'b0;
      end
      sum_op, difference_op, sum_with_carry_op, difference_with_borrow_op, step_up_op, step_down_op,
      compare_op, twos_complement_op: begin
        alu_word = word_q;
        alu_res = word_q ? ar[15:0] : {ar[7:0], ar[7:0]};
        alu_flags = with_nz(flag_q, ar[15:0], word_q);
        alu_flags[`CTAL_FLAG_V] = ar[17];
        // byte steps leave carry and half carry alone
        alu_flags[`CTAL_FLAG_C] = is_step ? c_in : ar[16];
        alu_flags[`CTAL_FLAG_H] = is_step ? flag_q[`CTAL_FLAG_H] : ar[18];
        alu_wr = op_q != compare_op;
      end
      pointer_step_up_op, pointer_step_down_op: begin
        alu_word = 1'b1;
        alu_res = (op_q == pointer_step_up_op) ? dw + pstep : dw - pstep;
      end
      decimal_fix_after_sum_op, decimal_fix_after_difference_op: begin
        alu_res[7:0] = (op_q == decimal_fix_after_sum_op) ? db + daa_adj : db - das_adj;
        alu_res[15:8] = alu_res[7:0];
        alu_flags = with_nz(flag_q, alu_res, 1'b0);
        alu_flags[`CTAL_FLAG_C] = (op_q == decimal_fix_after_sum_op) ? fix_hi : c_in;
      end
      unsigned_product_op: begin
        alu_word = 1'b1;
        alu_res = prod;
      end
      // quotient low, remainder high; divide by zero leaves the register
      unsigned_quotient_op: begin
        alu_word = 1'b1;
        alu_res = {rem[7:0], quo[7:0]};
        alu_wr = !div_zero;
        alu_flags[`CTAL_FLAG_N] = sb[7];
        alu_flags[`CTAL_FLAG_Z] = div_zero;
        alu_flags[`CTAL_FLAG_V] = quo[15:8] != 8'h00;
      end
      and_op, or_op, xor_op, invert_op: begin
        alu_res[7:0] = (op_q == and_op) ? (db & sb) : (op_q == or_op) ? (db | sb)
                       : (op_q == xor_op) ? (db ^ sb) : ~db;
        alu_res[15:8] = alu_res[7:0];
        alu_flags = with_nz(flag_q, alu_res, 1'b0);
        alu_flags[`CTAL_FLAG_V] = 1'b0;
      end
      default: begin
        alu_res = {sh_res, sh_res};
        alu_flags = with_nz(flag_q, alu_res, 1'b0);
        alu_flags[`CTAL_FLAG_C] = sh_c;
        alu_flags[`CTAL_FLAG_V] = sh_v;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // effective address and register file ports
  // ----------------------------------------------------------------
  logic [15:0] ea;

  always_comb begin
    case (mode_q)
      mode_disp16: ea = pv + imm_q;
      mode_abs8: ea = {`CTAL_ABS8_PAGE, imm_q[7:0]};
      mode_abs16: ea = imm_q;
      mode_predec: ea = pv - step;
      default: ea = pv;
    endcase
  end

  // word access drops address bit zero
  wire [15:0] ea_al = word_q ? (ea & `CTAL_WORD_ALIGN) : ea;
  wire exec_go = state_q == st_exec && cmd_ok;
  wire ack_go = state_q == st_mem && MEM_ACK;
  wire [1:0] byte_lane = dst_q[3] ? `CTAL_LANE_LOW : `CTAL_LANE_HIGH;
  wire [15:0] ld_data = word_q ? MEM_RDATA : {MEM_RDATA[7:0], MEM_RDATA[7:0]};
  wire a_en = (exec_go && !mem_access && alu_wr) || (ack_go && !store_q);
  wire [15:0] a_data = ack_go ? ld_data : alu_res;
  wire [1:0] a_lane = (ack_go ? word_q : alu_word) ? `CTAL_LANE_BOTH : byte_lane;
  wire b_en = (exec_go && mem_access && mode_q == mode_predec) || (ack_go && mode_q == mode_postinc);
  wire [15:0] b_data = (mode_q == mode_predec) ? pv - step : pv + step;

  ctal_regs u_regs (
    .clk(SYS_CLK),
    .rst_n(rst_n),
    .a_en(a_en),
    .a_idx(dst_q[2:0]),
    .a_lane(a_lane),
    .a_data(a_data),
    .b_en(b_en),
    .b_idx(ptr_q),
    .b_data(b_data),
    .file(file)
  );

  // ----------------------------------------------------------------
  // sequencer and registered outputs
  // ----------------------------------------------------------------
  ctal_state_t next_state;
  wire [15:0] st_data = word_q ? sw : {sb, sb};
  wire [15:0] ld_flag_src = word_q ? MEM_RDATA : {8'h00, MEM_RDATA[7:0]};

  always_comb begin
    case (state_q)
      st_idle: next_state = CMD_START ? st_exec : st_idle;
      st_exec: next_state = (cmd_ok && mem_access) ? st_mem : st_idle;
      st_mem: next_state = MEM_ACK ? st_idle : st_mem;
      default: next_state = st_idle;
    endcase
  end

  // memory request holds until acknowledged
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= st_idle;
      CMD_BUSY <= 1'b0;
      CMD_DONE <= 1'b0;
      CMD_ILLEGAL <= 1'b0;
      flag_q <= `CTAL_FLAGS_RESET;
      MEM_REQ <= 1'b0;
      MEM_WE <= 1'b0;
      MEM_WORD <= 1'b0;
      MEM_ADDR <= 16'h0000;
      MEM_WDATA <= 16'h0000;
      DBG_DATA <= 16'h0000;
    end else begin
      state_q <= next_state;
      CMD_BUSY <= next_state != st_idle;
      CMD_DONE <= (state_q == st_exec && !(cmd_ok && mem_access)) || ack_go;
      CMD_ILLEGAL <= state_q == st_exec && !cmd_ok;
      DBG_DATA <= word_of(file, DBG_SEL);
      if (exec_go && !mem_access) flag_q <= alu_flags;
      if (exec_go && mem_access && store_q) flag_q <= with_nz({flag_q[7:2], 1'b0, flag_q[0]}, st_data, word_q);
      if (ack_go && !store_q) flag_q <= with_nz({flag_q[7:2], 1'b0, flag_q[0]}, ld_flag_src, word_q);
      if (exec_go && mem_access) begin
        MEM_REQ <= 1'b1;
        MEM_WE <= store_q;
        MEM_WORD <= word_q;
        MEM_ADDR <= ea_al;
        MEM_WDATA <= st_data;
      end else if (ack_go) begin
        MEM_REQ <= 1'b0;
        MEM_WE <= 1'b0;
      end
    end
  end

  assign FLAGS = flag_q;

endmodule // ctal_core
`default_nettype wire

// ==== ctal_core_monitor.sv ====
// checker for the command and memory ports of ctal_core
// assumes: bound onto ctal_core, single clock domain
`timescale 1ns/1ps
`default_nettype none
module ctal_core_monitor import ctal_pkg::*; (
  input wire logic SYS_CLK, RESETN, CMD_START, CMD_WORD, CMD_BUSY, CMD_DONE, CMD_ILLEGAL,
  input wire ctal_op_t CMD_OP,
  input wire ctal_mode_t CMD_MODE,
  input wire logic MEM_REQ, MEM_WE, MEM_WORD, MEM_ACK,
  input wire logic [15:0] MEM_ADDR, MEM_WDATA
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  sequence s_take; CMD_START && !CMD_BUSY; endsequence
  sequence s_wait; MEM_REQ && !MEM_ACK; endsequence
  a_refuse_quiet: assert property (CMD_ILLEGAL |-> CMD_DONE && !MEM_REQ) else $error("bad refusal");
  a_reg_op_timing: assert property (s_take ##0 CMD_OP >= sum_op |-> ##2 CMD_DONE)
    else $error("register op late");
  a_busy_after_take: assert property (s_take |=> CMD_BUSY) else $error("busy missing");
  a_done_single: assert property (CMD_DONE |-> !CMD_BUSY ##1 !CMD_DONE) else $error("done too long");
  a_req_holds: assert property (s_wait |=> MEM_REQ && $stable(MEM_ADDR) && $stable(MEM_WE)
    && $stable(MEM_WDATA)) else $error("request moved");
  a_ack_ends: assert property (MEM_REQ && MEM_ACK |=> !MEM_REQ && CMD_DONE) else $error("no end");
  a_word_even: assert property (MEM_REQ && MEM_WORD |-> !MEM_ADDR[0]) else $error("odd word");
  a_push_word: assert property (s_take ##0 CMD_OP == stack_store_op |-> ##2 MEM_REQ && MEM_WE && MEM_WORD)
    else $error("push form");
  a_pop_word: assert property (s_take ##0 CMD_OP == stack_load_op |-> ##2 MEM_REQ && !MEM_WE && MEM_WORD)
    else $error("pop form");
  a_short_page: assert property (s_take ##0 (CMD_OP == transfer_op && CMD_MODE == mode_abs8 && !CMD_WORD)
    |-> ##2 MEM_REQ && MEM_ADDR[15:8] == 8'hff) else $error("short page");
endmodule // ctal_core_monitor
bind ctal_core ctal_core_monitor mon_u (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .CMD_START(CMD_START),
  .CMD_WORD(CMD_WORD), .CMD_BUSY(CMD_BUSY), .CMD_DONE(CMD_DONE), .CMD_ILLEGAL(CMD_ILLEGAL), .CMD_OP(CMD_OP),
  .CMD_MODE(CMD_MODE), .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_WORD(MEM_WORD), .MEM_ACK(MEM_ACK),
  .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA));
`default_nettype wire

// ==== ctal_mem_model.sv ====
// memory partner for ctal_core: byte array, one answer per request
// assumes: a request is held until its ack
`timescale 1ns/1ps
`default_nettype none
module ctal_mem_model (
  input wire logic clk, req, we, word,
  input wire logic [15:0] addr, wdata,
  input wire logic [1:0] lat,
  output logic ack = 1'b0,
  output logic [15:0] rdata = 16'h0
);
  logic [7:0] mem [0:65535];
  logic [1:0] cnt = 2'h0;
  // read data scrambles outside the answer cycle, so stale data never passes
  always @(posedge clk) begin
    ack <= 1'b0;
    rdata <= ~rdata;
    if (req && !ack) begin
      if (cnt != lat) cnt <= cnt + 2'h1;
      else begin
        cnt <= 2'h0;
        ack <= 1'b1;
        rdata <= word ? {mem[addr], mem[addr | 16'h1]} : {8'h00, mem[addr]};
        if (we && word) begin
          mem[addr] <= wdata[15:8];
          mem[addr | 16'h1] <= wdata[7:0];
        end
        else if (we) mem[addr] <= wdata[7:0];
      end
    end
  end
endmodule // ctal_mem_model
`default_nettype wire

// ==== ctal_pkg.sv ====
// types shared by the transfer, arithmetic, logic and shift core
// assumes: compiled before every module that imports it
package ctal_pkg;

  // ----------------------------------------------------------------
  // operations
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    transfer_op = 5'h00, stack_load_op = 5'h01, stack_store_op = 5'h02,
    sum_op = 5'h03, difference_op = 5'h04, sum_with_carry_op = 5'h05,
    difference_with_borrow_op = 5'h06, step_up_op = 5'h07, step_down_op = 5'h08,
    pointer_step_up_op = 5'h09, pointer_step_down_op = 5'h0a,
    decimal_fix_after_sum_op = 5'h0b, decimal_fix_after_difference_op = 5'h0c,
    unsigned_product_op = 5'h0d, unsigned_quotient_op = 5'h0e, compare_op = 5'h0f,
    twos_complement_op = 5'h10, and_op = 5'h11, or_op = 5'h12, xor_op = 5'h13,
    invert_op = 5'h14, arith_left_shift_op = 5'h15, arith_right_shift_op = 5'h16,
    logic_left_shift_op = 5'h17, logic_right_shift_op = 5'h18, left_rotate_op = 5'h19,
    right_rotate_op = 5'h1a, carry_left_rotate_op = 5'h1b, carry_right_rotate_op = 5'h1c
  } ctal_op_t;

  // ----------------------------------------------------------------
  // operand addressing modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    mode_register = 3'h0, mode_indirect = 3'h1, mode_disp16 = 3'h2, mode_abs8 = 3'h3,
    mode_abs16 = 3'h4, mode_immediate = 3'h5, mode_predec = 3'h6, mode_postinc = 3'h7
  } ctal_mode_t;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    st_idle = 2'b00, st_exec = 2'b01, st_mem = 2'b10
  } ctal_state_t;

endpackage

// ==== ctal_regs.sv ====
// general register file: eight 16-bit registers, each two byte halves
// assumes: single clock, reset already synchronised by the caller
`timescale 1ns/1ps
`default_nettype none
`include "ctal_consts.svh"

module ctal_regs (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // data write with byte lanes
  input wire logic a_en,
  input wire logic [2:0] a_idx,
  input wire logic [1:0] a_lane,
  input wire logic [15:0] a_data,
  // pointer write, whole word
  input wire logic b_en,
  input wire logic [2:0] b_idx,
  input wire logic [15:0] b_data,
  // whole file, register n at bits 16n+15..16n
  output logic [127:0] file
);

  logic [15:0] mem [8];

  // data port is written last so it wins over a pointer update
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) mem[i] <= `CTAL_REG_RESET;
    end else begin
      if (b_en) mem[b_idx] <= b_data;
      if (a_en && a_lane[1]) mem[a_idx][15:8] <= a_data[15:8];
      if (a_en && a_lane[0]) mem[a_idx][7:0] <= a_data[7:0];
    end
  end

  // flatten for the reader
  always_comb begin
    file = 128'h0;
    for (int i = 0; i < 8; i++) file[i*16 +: 16] = mem[i];
  end

endmodule // ctal_regs
`default_nettype wire

// ==== ctal_shift.sv ====
// one-bit byte shifter and rotator
// assumes: purely combinational, caller registers the result
`timescale 1ns/1ps
`default_nettype none

module ctal_shift (
  // operation and operand
  input wire ctal_pkg::ctal_op_t op,
  input wire logic [7:0] val,
  input wire logic c_in,
  // result
  output logic [7:0] res,
  output logic c_out,
  output logic v_out
);
  import ctal_pkg::*;

  // every form moves one place; the bit leaving lands in carry
  always_comb begin
    res = val;
    c_out = c_in;
    v_out = 1'b0;
    case (op)
      arith_left_shift_op: begin
        res = {val[6:0], 1'b0};
        c_out = val[7];
        v_out = val[7] ^ val[6]; // sign change means overflow
      end
      arith_right_shift_op: begin
        res = {val[7], val[7:1]};
        c_out = val[0];
      end
      logic_left_shift_op: begin
        res = {val[6:0], 1'b0};
        c_out = val[7];
      end
      logic_right_shift_op: begin
        res = {1'b0, val[7:1]};
        c_out = val[0];
      end
      left_rotate_op: begin
        res = {val[6:0], val[7]};
        c_out = val[7];
      end
      right_rotate_op: begin
        res = {val[0], val[7:1]};
        c_out = val[0];
      end
      carry_left_rotate_op: begin
        res = {val[6:0], c_in};
        c_out = val[7];
      end
      carry_right_rotate_op: begin
        res = {c_in, val[7:1]};
        c_out = val[0];
      end
      default: begin
        res = val;
      end
    endcase
  end

endmodule // ctal_shift
`default_nettype wire

// ==== testbench.sv ====
// self-checking bench for ctal_core with the memory partner
// assumes: package, design, partner and checker compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ctal_pkg::*;
  logic clk = 0, rst_n = 0, start = 0, word = 0, store = 0, was_ill = 0;
  ctal_op_t op = transfer_op;
  ctal_mode_t mode = mode_register;
  logic [3:0] dst = 0, src = 0;
  logic [2:0] sel = 0;
  logic [1:0] lat = 0;
  logic [15:0] imm = 0, v;
  wire logic busy, done, ill, req, we, mw, ack;
  wire logic [7:0] flags;
  wire logic [15:0] addr, wd, rd, dbg;
  int bad_count = 0, total_checks = 0;
  ctal_op_t sh [8] = '{logic_right_shift_op, arith_right_shift_op, logic_left_shift_op, arith_left_shift_op,
    left_rotate_op, right_rotate_op, carry_left_rotate_op, carry_right_rotate_op};
  logic [7:0] ex [8] = '{8'h40, 8'hc0, 8'h02, 8'h02, 8'h03, 8'hc0, 8'h03, 8'hc0};
  initial forever #4 clk = ~clk;
  ctal_core dut_u (.SYS_CLK(clk), .RESETN(rst_n), .CMD_START(start), .CMD_OP(op), .CMD_WORD(word),
    .CMD_MODE(mode), .CMD_STORE(store), .CMD_DST(dst), .CMD_SRC(src), .CMD_PTR(3'h7), .CMD_IMM(imm),
    .CMD_BUSY(busy), .CMD_DONE(done), .CMD_ILLEGAL(ill), .FLAGS(flags), .MEM_REQ(req), .MEM_WE(we),
    .MEM_WORD(mw), .MEM_ADDR(addr), .MEM_WDATA(wd), .MEM_RDATA(rd), .MEM_ACK(ack), .DBG_SEL(sel),
    .DBG_DATA(dbg));
  ctal_mem_model mem_u (.clk(clk), .req(req), .we(we), .word(mw), .addr(addr), .wdata(wd), .lat(lat),
    .ack(ack), .rdata(rd));
  task check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // one command, then a bounded wait for its done pulse
  task cmd(input ctal_op_t o, input logic w, input ctal_mode_t m, input logic s, input logic [3:0] d,
    input logic [3:0] r, input logic [15:0] i);
    int n;
    n = 0;
    @(posedge clk);
    op <= o;
    mode <= m;
    {word, store, dst, src, imm, start} <= {w, s, d, r, i, 1'b1};
    @(posedge clk);
    start <= 1'b0;
    while (done !== 1'b1) begin
      @(posedge clk);
      n++;
      if (n > 20) begin bad_count++; complete_run; end
    end
    was_ill = ill;
  endtask
  // register view answers one cycle late; three edges leave margin
  task rdreg(input logic [2:0] r);
    sel <= r;
    repeat (3) @(posedge clk);
    v = dbg;
  endtask
  task t_sum;
    cmd(transfer_op, 1, mode_immediate, 0, 4'h1, 4'h0, 16'h1234);
    rdreg(3'h1); check(v, 16'h1234);
    cmd(sum_op, 0, mode_register, 0, 4'h1, 4'h9, 16'h0);
    rdreg(3'h1); check(v, 16'h4634);
    cmd(difference_op, 0, mode_immediate, 0, 4'h1, 4'h0, 16'h0005);
    check({15'h0, was_ill}, 16'h0001);
    rdreg(3'h1); check(v, 16'h4634);
  endtask
  // arithmetic and logic; each step builds on the last
  task t_arith;
    cmd(transfer_op, 1, mode_immediate, 0, 4'h0, 4'h0, 16'hfaff);
    cmd(unsigned_product_op, 0, mode_register, 0, 4'h0, 4'h0, 16'h0);
    rdreg(3'h0); check(v, 16'hf906);
    cmd(transfer_op, 1, mode_immediate, 0, 4'h2, 4'h0, 16'h0407);
    cmd(unsigned_quotient_op, 0, mode_register, 0, 4'h2, 4'h8, 16'h0);
    rdreg(3'h2); check(v, 16'h05ab);
    cmd(compare_op, 1, mode_register, 0, 4'h2, 4'h0, 16'h0);
    rdreg(3'h2); check(v, 16'h05ab);
    check({15'h0, flags[0]}, 16'h0001);
    cmd(compare_op, 1, mode_immediate, 0, 4'h2, 4'h0, 16'h05ab);
    check({15'h0, was_ill}, 16'h0001);
    cmd(twos_complement_op, 0, mode_register, 0, 4'h8, 4'h0, 16'h0);
    rdreg(3'h0); check(v, 16'hf9fa);
    cmd(invert_op, 0, mode_register, 0, 4'h0, 4'h0, 16'h0);
    rdreg(3'h0); check(v, 16'h06fa);
    cmd(xor_op, 0, mode_immediate, 0, 4'h0, 4'h0, 16'h00ff);
    rdreg(3'h0); check(v, 16'hf9fa);
    cmd(step_down_op, 0, mode_register, 0, 4'h8, 4'h0, 16'h0);
    cmd(pointer_step_down_op, 1, mode_register, 0, 4'h0, 4'h0, 16'h0002);
    rdreg(3'h0); check(v, 16'hf9f7);
    cmd(sum_with_carry_op, 0, mode_immediate, 0, 4'h8, 4'h0, 16'h0021);
    rdreg(3'h0); check(v, 16'hf919);
    cmd(decimal_fix_after_sum_op, 0, mode_register, 0, 4'h8, 4'h0, 16'h0);
    rdreg(3'h0); check(v, 16'hf979);
  endtask
  // each shift starts from 8'h81, so every one pushes a one into carry
  task t_shift;
    for (int k = 0; k < 8; k++) begin
      cmd(transfer_op, 0, mode_immediate, 0, 4'hb, 4'h0, 16'h0081);
      cmd(sh[k], 0, mode_register, 0, 4'hb, 4'hb, 16'h0);
      rdreg(3'h3); check(v, {8'h00, ex[k]});
      check({15'h0, flags[0]}, 16'h0001);
    end
  endtask
  // slow memory for the stack; stack steps are always word sized
  // no byte step through the stack pointer
  task t_stack;
    lat <= 2'h2;
    cmd(transfer_op, 1, mode_immediate, 0, 4'h7, 4'h0, 16'h0100);
    cmd(transfer_op, 1, mode_immediate, 0, 4'h2, 4'h0, 16'hbeef);
    cmd(stack_store_op, 1, mode_predec, 1, 4'h0, 4'h2, 16'h0);
    rdreg(3'h7); check(v, 16'h00fe);
    cmd(stack_load_op, 1, mode_postinc, 0, 4'h4, 4'h0, 16'h0);
    rdreg(3'h4); check(v, 16'hbeef);
    rdreg(3'h7); check(v, 16'h0100);
    lat <= 2'h0;
    cmd(transfer_op, 1, mode_abs16, 0, 4'h5, 4'h0, 16'h00ff);
    rdreg(3'h5); check(v, 16'hbeef);
    cmd(transfer_op, 0, mode_abs8, 1, 4'h0, 4'ha, 16'h0010);
    cmd(transfer_op, 0, mode_abs8, 0, 4'he, 4'h0, 16'h0010);
    rdreg(3'h6); check(v, 16'h00ef);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_sum;
    t_arith;
    t_shift;
    t_stack;
    complete_run;
  end
endmodule // testbench
`default_nettype wire
